// ==== pics_supervisor.sv ====
// Contract
// R01: Host picks divider so system tick fits
// R02: Skip mode keeps lock through 20 ms gaps
// R03: Host uses skip only below 80 kHz
// R04: Output kept for 2^23 ticks after removal
// R05: Glitch on removal unlocks at once
// R06: After time-out, unlock, output per bit
// R07: Return after time-out: acquire, then lock
// R08: Skip late return may hide wrong frequency
// R09: Host clears skip for late returns
// R10: No skip: unlock only while reacquiring
// R11: Skip: output continuous through gap, relock
// R12: Three-bit field selects 1 to 128 Hz
// R13: Loop corner passes low, rejects high jitter
// R14: Wide bandwidth forced while acquiring lock
// R15: Locked bandwidth settles to selected minimum
// R16: Removal counted from last edge, restarted
`timescale 1ns/100ps
`include "pics_consts.svh"
module pics_supervisor
    import pics_pkg::*;
#(
    parameter int SKIP_CYCLES = `PICS_SKIP_MS * `PICS_CLK_MHZ * 1000,
    parameter int TIMEOUT_TICKS = `PICS_TIMEOUT_TICKS,
    parameter int ACQ_CYCLES = `PICS_ACQ_US * `PICS_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire pics_bus_t bus_req,
    output logic [31:0] bus_rdata,
    // Frequency reference, sampled on clk_sys
    input wire logic freq_ref_in,
    // Loop and output control
    output logic internal_timing_tick,
    output logic pll_locked,
    output logic clk_out_enable,
    output logic [2:0] loop_bw_sel,
    output logic [7:0] loop_bw_hz,
    // Interrupt
    output logic irq
);
    // ****************************************
    // Decoding helpers
    // ****************************************
    // Tick mask for divide by 1, 2, 4 or 8
    function automatic logic [2:0] pics_div_mask(input logic [1:0] sel);
        case (sel)
            2'h0: pics_div_mask = 3'h0;
            2'h1: pics_div_mask = 3'h1;
            2'h2: pics_div_mask = 3'h3;
            default: pics_div_mask = 3'h7;
        endcase
    endfunction

    pics_ctrl_t ctrl_r;
    pics_state_t state_r, state_nxt;
    logic [2:0] div_cnt_r;
    logic ref_d_r;
    logic [23:0] gap_cnt_r, tick_cnt_r, period_r, acq_cnt_r;
    logic [3:0] int_stat_r, int_mask_r, events;
    logic [31:0] rdata_r;
    logic locked_r, out_en_r;
    logic [2:0] bw_r;

    // ****************************************
    // Register decode
    // ****************************************
    wire wr_ctrl = bus_req.wr && bus_req.addr == `PICS_ADDR_CTRL;
    wire wr_mask = bus_req.wr && bus_req.addr == `PICS_ADDR_INT_MASK;
    wire rd_stat = bus_req.rd && bus_req.addr == `PICS_ADDR_INT_STAT;
    wire [31:0] status_word = {20'h0, state_r, 3'h0, bw_r, out_en_r, locked_r};
    wire [31:0] rd_mux =
        (bus_req.addr == `PICS_ADDR_CTRL) ? {25'h0, ctrl_r} :
        (bus_req.addr == `PICS_ADDR_STATUS) ? status_word :
        (bus_req.addr == `PICS_ADDR_INT_STAT) ? {28'h0, int_stat_r} :
        (bus_req.addr == `PICS_ADDR_INT_MASK) ? {28'h0, int_mask_r} :
        32'h0;

    // ****************************************
    // Reference divider and edge timing
    // ****************************************
    // Host keeps the divided rate legal; no range check here [R01]
    wire [2:0] div_mask = pics_div_mask(ctrl_r.ref_divider_sel);
    wire tick = (div_cnt_r | ~div_mask) == 3'h7;
    wire ref_edge = freq_ref_in && !ref_d_r;
    // Absent once the gap exceeds two periods
    wire absent = period_r != 24'h0 && gap_cnt_r > {period_r[22:0], 1'b0};
    // Interval under half a period is a frequency change [R05]
    wire short_edge = ref_edge && gap_cnt_r < {1'b0, period_r[23:1]};
    wire timeout_hit = tick_cnt_r >= TIMEOUT_TICKS[23:0];
    wire acq_done = acq_cnt_r >= ACQ_CYCLES[23:0] - 24'h1;
    // Skip window is only watched by checks; lock is never gated by it
    wire in_skip = gap_cnt_r <= SKIP_CYCLES[23:0];
    // Gaps that end an absence would corrupt the period estimate
    wire keep_period = state_r == PICS_LOCKED || state_r == PICS_ACQ;

    // Divider counter, free running
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_cnt_r <= 3'h0;
        end else begin
            div_cnt_r <= tick ? 3'h0 : div_cnt_r + 3'h1;
        end
    end

    // Cycles and ticks since last edge, restarted on each edge [R16]
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ref_d_r <= 1'b0;
            gap_cnt_r <= 24'h0;
            tick_cnt_r <= 24'h0;
            period_r <= 24'h0;
        end else begin
            ref_d_r <= freq_ref_in;
            if (ref_edge) begin
                gap_cnt_r <= 24'h0;
                tick_cnt_r <= 24'h0;
                if (keep_period) begin
                    period_r <= gap_cnt_r;
                end
            end else begin
                if (gap_cnt_r != `PICS_CNT_MAX) begin
                    gap_cnt_r <= gap_cnt_r + 24'h1;
                end
                if (tick && tick_cnt_r != `PICS_CNT_MAX) begin
                    tick_cnt_r <= tick_cnt_r + 24'h1;
                end
            end
        end
    end

    // ****************************************
    // Lock supervisor
    // ****************************************
    // Next state from edge, gap and skip setting
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PICS_LOCKED: begin
                if (short_edge) begin
                    state_nxt = PICS_ACQ; // [R05]
                end else if (absent) begin
                    state_nxt = PICS_HOLD; // [R04]
                end
            end
            PICS_HOLD: begin
                if (ref_edge) begin
                    // Late return under skip stays locked, unflagged [R08] [R02] [R11]
                    state_nxt = ctrl_r.skip_mode_enable ? PICS_LOCKED : PICS_ACQ; // [R10]
                end else if (timeout_hit) begin
                    state_nxt = PICS_UNLOCK; // [R06]
                end
            end
            PICS_UNLOCK: begin
                if (ref_edge) begin
                    state_nxt = PICS_ACQ; // [R07]
                end
            end
            PICS_ACQ: begin
                if (acq_done) begin
                    state_nxt = PICS_LOCKED; // [R07]
                end
            end
            default: state_nxt = PICS_UNLOCK;
        endcase
    end

    // Lock indication and output gating follow next state
    wire lock_nxt = state_nxt == PICS_LOCKED || state_nxt == PICS_HOLD;
    wire out_en_nxt = lock_nxt || ctrl_r.output_on_unlock_enable; // [R06] [R10]
    // Wide while acquiring, selected minimum once locked [R14] [R15]
    wire [2:0] bw_nxt = lock_nxt ? ctrl_r.min_loop_bandwidth_sel : `PICS_BW_WIDE;

    // State, acquisition timer and registered outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= PICS_UNLOCK;
            acq_cnt_r <= 24'h0;
            locked_r <= 1'b0;
            out_en_r <= 1'b0;
            bw_r <= `PICS_BW_WIDE;
        end else begin
            state_r <= state_nxt;
            acq_cnt_r <= (state_r == PICS_ACQ) ? acq_cnt_r + 24'h1 : 24'h0;
            locked_r <= lock_nxt;
            out_en_r <= out_en_nxt;
            bw_r <= bw_nxt;
        end
    end

    // ****************************************
    // Registers and interrupt
    // ****************************************
    assign events[`PICS_EV_LOST] = locked_r && !lock_nxt;
    assign events[`PICS_EV_GAINED] = !locked_r && lock_nxt;
    assign events[`PICS_EV_GLITCH] = state_r == PICS_LOCKED && short_edge;
    assign events[`PICS_EV_REMOVED] = state_r == PICS_LOCKED && state_nxt == PICS_HOLD;

    // Read clears status; a same-cycle event still lands
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_r <= `PICS_CTRL_RST;
            int_stat_r <= `PICS_INT_RST;
            int_mask_r <= `PICS_INT_RST;
            rdata_r <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= bus_req.wdata[6:0];
            end
            if (wr_mask) begin
                int_mask_r <= bus_req.wdata[3:0];
            end
            int_stat_r <= (rd_stat ? 4'h0 : int_stat_r) | events;
            rdata_r <= bus_req.rd ? rd_mux : 32'h0;
        end
    end

    assign bus_rdata = rdata_r;
    assign internal_timing_tick = tick;
    assign pll_locked = locked_r;
    assign clk_out_enable = out_en_r;
    // Corner rises with the code: 1 Hz to 128 Hz [R12] [R13]
    assign loop_bw_sel = bw_r;
    assign loop_bw_hz = 8'h01 << bw_r;
    assign irq = |(int_stat_r & int_mask_r);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_hold_edge;
        state_r == PICS_HOLD && ref_edge;
    endsequence
    sequence s_locked_glitch;
        state_r == PICS_LOCKED && short_edge;
    endsequence

    property p_skip_keep;
        s_hold_edge ##0 ctrl_r.skip_mode_enable |=> state_r == PICS_LOCKED && pll_locked;
    endproperty
    a_skip_keep: assert property (p_skip_keep) else $error("skip return lost lock"); // [R02]
    property p_hold_out;
        state_r == PICS_HOLD |-> clk_out_enable && pll_locked;
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("output dropped in hold"); // [R04]
    property p_glitch;
        s_locked_glitch |=> state_r == PICS_ACQ && !pll_locked;
    endproperty
    a_glitch: assert property (p_glitch) else $error("glitch did not unlock"); // [R05]
    property p_timeout;
        state_r == PICS_HOLD && timeout_hit && !ref_edge |=> state_r == PICS_UNLOCK;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out did not unlock"); // [R06]
    property p_unl_out;
        !pll_locked |-> clk_out_enable == ctrl_r.output_on_unlock_enable;
    endproperty
    a_unl_out: assert property (p_unl_out) else $error("unlock output wrong"); // [R06]
    property p_relock;
        state_r == PICS_UNLOCK && ref_edge |=> state_r == PICS_ACQ ##0 !pll_locked[*2];
    endproperty
    a_relock: assert property (p_relock) else $error("return not acquired"); // [R07]
    property p_noskip;
        s_hold_edge ##0 !ctrl_r.skip_mode_enable |=> state_r == PICS_ACQ;
    endproperty
    a_noskip: assert property (p_noskip) else $error("no-skip return stayed locked"); // [R10]
    property p_bw_wide;
        !pll_locked |-> loop_bw_sel == `PICS_BW_WIDE;
    endproperty
    a_bw_wide: assert property (p_bw_wide) else $error("bandwidth not wide"); // [R14]
    property p_bw_min;
        pll_locked && $stable(ctrl_r) |-> loop_bw_sel == ctrl_r.min_loop_bandwidth_sel;
    endproperty
    a_bw_min: assert property (p_bw_min) else $error("locked bandwidth wrong"); // [R15]
    property p_bw_hz;
        $onehot(loop_bw_hz) && loop_bw_hz[loop_bw_sel];
    endproperty
    a_bw_hz: assert property (p_bw_hz) else $error("bandwidth Hz mismatch"); // [R12]
    property p_gap_restart;
        ref_edge |=> gap_cnt_r == 24'h0 ##1 gap_cnt_r <= 24'h1;
    endproperty
    a_gap_restart: assert property (p_gap_restart) else $error("gap not restarted"); // [R16]

    sequence s_acq_end;
        state_r == PICS_ACQ && acq_done;
    endsequence
    // Gap inside the skip window never drops the output under skip
    property p_skip_window;
        state_r == PICS_HOLD && ctrl_r.skip_mode_enable && in_skip
            |-> clk_out_enable && pll_locked;
    endproperty
    a_skip_window: assert property (p_skip_window) else $error("skip window output lost"); // [R11]
    property p_late_quiet;
        s_hold_edge ##0 (ctrl_r.skip_mode_enable && !in_skip) |-> !events[`PICS_EV_LOST] ##1 pll_locked;
    endproperty
    a_late_quiet: assert property (p_late_quiet) else $error("late skip return flagged"); // [R08]
    property p_gained;
        s_acq_end |=> pll_locked && int_stat_r[`PICS_EV_GAINED];
    endproperty
    a_gained: assert property (p_gained) else $error("acquire end did not lock"); // [R07]
endmodule

// ==== pics_consts.svh ====
`ifndef PICS_CONSTS_SVH
`define PICS_CONSTS_SVH
// Clock rate and times in their own units
`define PICS_CLK_MHZ 250
`define PICS_SKIP_MS 20
`define PICS_ACQ_US 100
`define PICS_TIMEOUT_TICKS 32'h0080_0000
// Register byte addresses
`define PICS_ADDR_CTRL 8'h00
`define PICS_ADDR_STATUS 8'h04
`define PICS_ADDR_INT_STAT 8'h08
`define PICS_ADDR_INT_MASK 8'h0c
// Reset values and loop constants
`define PICS_CTRL_RST 7'h00
`define PICS_INT_RST 4'h0
`define PICS_BW_WIDE 3'h7
`define PICS_CNT_MAX 24'hff_ffff
// Event bit positions
`define PICS_EV_LOST 0
`define PICS_EV_GAINED 1
`define PICS_EV_GLITCH 2
`define PICS_EV_REMOVED 3
`endif

// ==== pics_pkg.sv ====
package pics_pkg;
    // Supervisor states, one-hot
    typedef enum logic [3:0] {
        PICS_LOCKED = 4'b0001,
        PICS_HOLD = 4'b0010,
        PICS_UNLOCK = 4'b0100,
        PICS_ACQ = 4'b1000
    } pics_state_t;
    // Control register layout, high bits first from the left
    typedef struct packed {
        logic [2:0] min_loop_bandwidth_sel;
        logic output_on_unlock_enable;
        logic skip_mode_enable;
        logic [1:0] ref_divider_sel;
    } pics_ctrl_t;
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pics_bus_t;
endpackage

// ==== pics_ref_model.sv ====
`timescale 1ns/100ps
// ****************************************
// Frequency reference source model
// ****************************************
module pics_ref_model #(
    parameter int PERIOD = 20
) (
    // Clock
    input wire logic clk_sys,
    // Source control
    input wire logic run,
    input wire logic glitch,
    // Reference line
    output logic freq_ref_in
);
    int cnt = 0;

    // Square wave while running; a removed source rests low
    always @(posedge clk_sys) begin
        if (!run) begin
            cnt <= 0;
            freq_ref_in <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1; // Slow source
            // A short dip makes an early edge, seen as a period change
            freq_ref_in <= (cnt < PERIOD / 2) && !(glitch && cnt == 2);
        end
    end
endmodule

// ==== pll_input_clock_supervisor_test.sv ====
`timescale 1ns/100ps
`include "pics_consts.svh"
module pll_input_clock_supervisor_test
    import pics_pkg::*;
();
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    pics_bus_t bus_req = '0;
    logic [31:0] bus_rdata;
    logic freq_ref_in;
    logic internal_timing_tick;
    logic pll_locked;
    logic clk_out_enable;
    logic irq;
    logic [2:0] loop_bw_sel;
    logic [7:0] loop_bw_hz;
    logic ref_run = 1'b0;
    logic ref_glitch = 1'b0;
    logic watch = 1'b0;
    logic dropped = 1'b0;
    logic [31:0] rd;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    int t0;
    int s;

    // ****************************************
    // Clock, design and source
    // ****************************************
    always #2 clk_sys = ~clk_sys;

    pics_supervisor #(.SKIP_CYCLES(200), .TIMEOUT_TICKS(1000), .ACQ_CYCLES(50)) dut (
        .clk_sys(clk_sys), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .freq_ref_in(freq_ref_in), .internal_timing_tick(internal_timing_tick),
        .pll_locked(pll_locked), .clk_out_enable(clk_out_enable),
        .loop_bw_sel(loop_bw_sel), .loop_bw_hz(loop_bw_hz), .irq(irq));

    pics_ref_model #(.PERIOD(20)) ref_src (
        .clk_sys(clk_sys), .run(ref_run), .glitch(ref_glitch), .freq_ref_in(freq_ref_in));

    // ****************************************
    // Tasks
    // ****************************************
    task report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rdv(input logic [7:0] a);
        @(posedge clk_sys);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        #1 rd = bus_rdata;
    endtask

    // Bounded wait for the lock level; n counts cycles
    task wait_lock(input logic v);
        n = 0;
        #1;
        while (pll_locked !== v && n < 3000) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask

    // Cycle ceiling well above the expected few thousand; watch for output drops
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (watch && (pll_locked !== 1'b1 || clk_out_enable !== 1'b1))
            dropped <= 1'b1;
        if (cycles == 30000) begin
            failures++;
            report_and_stop;
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        #1 check("bw_hz", loop_bw_hz, 32'd128);
        check("irq", irq, 1'b0);
        rdv(`PICS_ADDR_CTRL);
        check("ctrl", rd, 32'h0);
        rdv(8'h10);
        check("unmapped", rd, 32'h0);
        wr(`PICS_ADDR_CTRL, 32'h30);
        wr(`PICS_ADDR_INT_MASK, 32'hf);
        ref_run <= 1'b1;
        repeat (10) @(posedge clk_sys);
        #1 check("bw_acq", loop_bw_sel, 3'h7);
        wait_lock(1'b1);
        repeat (2) @(posedge clk_sys);
        #1 check("bw_hz", loop_bw_hz, 8'd8);
        check("irq", irq, 1'b1);
        rdv(`PICS_ADDR_STATUS);
        check("status", rd, 32'h10f);
        rdv(`PICS_ADDR_INT_STAT);
        check("int_stat", rd, 32'h2);
        rdv(`PICS_ADDR_INT_STAT);
        check("int_clear", rd, 32'h0);
        $display("test acquire done");
        // Long removal, output off on unlock
        @(posedge clk_sys);
        ref_run <= 1'b0;
        t0 = cycles;
        repeat (60) @(posedge clk_sys);
        #1 check("hold_lock", {pll_locked, clk_out_enable}, 2'b11);
        rdv(`PICS_ADDR_INT_STAT);
        check("removed", rd, 32'h8);
        wait_lock(1'b0);
        check("timeout", (cycles - t0 >= 970) && (cycles - t0 <= 1010), 1'b1);
        check("out_off", clk_out_enable, 1'b0);
        check("bw_unl", loop_bw_sel, 3'h7);
        wr(`PICS_ADDR_INT_MASK, 32'h0);
        #1 check("irq_mask", irq, 1'b0);
        rdv(`PICS_ADDR_INT_STAT);
        check("lost", rd, 32'h1);
        wr(`PICS_ADDR_INT_MASK, 32'hf);
        ref_run <= 1'b1;
        wait_lock(1'b1);
        check("reacq", n >= 50, 1'b1);
        $display("test timeout done");
        // Short gap with skipping on
        wr(`PICS_ADDR_CTRL, 32'h34);
        watch <= 1'b1;
        ref_run <= 1'b0;
        repeat (100) @(posedge clk_sys);
        ref_run <= 1'b1;
        repeat (100) @(posedge clk_sys);
        watch <= 1'b0;
        #1 check("skip_gap", dropped, 1'b0);
        // Late return under skip: no unlock shown, frequency left unchecked
        rdv(`PICS_ADDR_INT_STAT);
        watch <= 1'b1;
        ref_run <= 1'b0;
        repeat (300) @(posedge clk_sys);
        ref_run <= 1'b1;
        repeat (100) @(posedge clk_sys);
        watch <= 1'b0;
        rdv(`PICS_ADDR_INT_STAT);
        check("late_skip", {dropped, rd[0]}, 2'b00);
        $display("test skip done");
        // Short gap without skipping, output kept on unlock
        wr(`PICS_ADDR_CTRL, 32'h38); // Skip off for this gap
        ref_run <= 1'b0;
        repeat (100) @(posedge clk_sys);
        #1 check("gap_lock", pll_locked, 1'b1);
        ref_run <= 1'b1;
        wait_lock(1'b0);
        check("reacq_fast", n < 30, 1'b1);
        check("out_kept", clk_out_enable, 1'b1);
        wait_lock(1'b1);
        $display("test noskip done");
        // Glitch unlocks at once
        ref_glitch <= 1'b1;
        wait_lock(1'b0);
        ref_glitch <= 1'b0;
        check("glitch", n <= 25, 1'b1);
        rdv(`PICS_ADDR_INT_STAT);
        check("glitch_ev", rd[2], 1'b1);
        wait_lock(1'b1);
        $display("test glitch done");
        // Every bandwidth code, then every divider
        for (int k = 0; k < 8; k++) begin
            wr(`PICS_ADDR_CTRL, 32'h8 | (k << 4));
            repeat (2) @(posedge clk_sys);
            #1 check("bw_code", loop_bw_hz, 8'h1 << k);
        end
        for (int d = 0; d < 4; d++) begin
            wr(`PICS_ADDR_CTRL, d);
            s = 0;
            repeat (64) begin
                @(posedge clk_sys);
                #1 s += (internal_timing_tick === 1'b1);
            end
            check("ticks", s, 64 >> d);
        end
        $display("test codes done");
        report_and_stop;
    end
endmodule
